//--- bench/mas_host_master.sv
// host serial master model, 160 ns serial clock
// assumes the bench calls its tasks one at a time
`timescale 1ns/1ps
module mas_host_master (
    output logic      sclk,
    output logic      csN,
    output logic      sdi,
    input  wire logic sdoData
);
    initial begin
        sclk = 1'b0;
        csN  = 1'b1;
        sdi  = 1'b0;
    end
    task automatic xfer(input logic cpol, input int n, input logic [15:0] mosi,
                        output logic [15:0] miso);
        miso = 16'h0000;
        #37 sclk = cpol;
        #40 csN = 1'b0;
        for (int i = 0; i < n; i++) begin
            if (cpol) sclk = 1'b0;
            sdi = mosi[n-1-i];
            #80 miso = {miso[14:0], sdoData};
            sclk = 1'b1;
            #80 if (!cpol) sclk = 1'b0;
        end
        #50 csN = 1'b1;
        sdi = ~sdi;
        #80;
    endtask
    // clock edges with select high
    task automatic idle_clocks(input int n);
        repeat (n) begin
            #80 sclk = ~sclk;
            sdi = ~sdi;
        end
    endtask
endmodule // mas_host_master

//--- bench/mas_serial_port_checker.sv
// port checker for the monitor serial port and its alarm pin
// assumes it is bound onto mas_serial_port; core clock clk
`timescale 1ns/1ps
module mas_serial_port_checker (
    input wire logic                    clk,
    input wire logic                    reset,
    input wire logic                    sclk,
    input wire logic                    csN,
    input wire logic                    sdoData,
    input wire logic                    sdoOeN,
    input wire logic                    txReady,
    input wire logic                    rxValid,
    input wire logic                    frameActive,
    input wire logic                    frameStart,
    input wire logic                    alarmEvent,
    input wire logic                    alarmClear,
    input wire mas_pkg::mas_alarm_cfg_s alarmCfg,
    input wire logic                    alarmPinOut,
    input wire logic                    alarmPinOeN
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    chk_oe_follows_cs: assert property (sdoOeN == csN)
        else $error("serial output enable differs from select");
    chk_sdo_edge_only: assert property (
        !csN && $stable(csN) && $stable(sclk) |-> $stable(sdoData))
        else $error("serial output moved without a clock edge");
    chk_rx_in_frame: assert property (rxValid |-> frameActive)
        else $error("word received outside a frame");
    chk_start_single: assert property (frameStart |=> !frameStart)
        else $error("frame start longer than one cycle");
    chk_ready_idle: assert property (txReady |-> !frameActive)
        else $error("transmit ready during a frame");
    // pin flop follows the sticky state one edge after the event or clear
    chk_alarm_push: assert property (alarmEvent && !alarmCfg.openDrain |-> ##1
        (!alarmPinOeN && alarmPinOut == alarmCfg.activeHigh)) else $error("push-pull alarm wrong");
    chk_alarm_drain: assert property (alarmEvent && alarmCfg.openDrain |-> ##1
        (!alarmPinOut && alarmPinOeN == alarmCfg.activeHigh)) else $error("open-drain alarm wrong");
    chk_alarm_clear: assert property (alarmClear && !alarmEvent && !alarmCfg.openDrain |-> ##1
        (!alarmPinOeN && alarmPinOut != alarmCfg.activeHigh)) else $error("alarm not cleared");
    cover property (rxValid);
    cover property (frameStart);
    cover property (frameStart && sclk);
    cover property (alarmEvent && alarmCfg.openDrain);
endmodule // mas_serial_port_checker
bind mas_serial_port mas_serial_port_checker chk (.clk(clk), .reset(reset), .sclk(sclk),
    .csN(csN), .sdoData(sdoData), .sdoOeN(sdoOeN), .txReady(txReady), .rxValid(rxValid),
    .frameActive(frameActive), .frameStart(frameStart), .alarmEvent(alarmEvent),
    .alarmClear(alarmClear), .alarmCfg(alarmCfg), .alarmPinOut(alarmPinOut),
    .alarmPinOeN(alarmPinOeN));

//--- bench/mas_serial_port_test.sv
// self-checking bench of the monitor serial port
// assumes package, design and host model compiled before it
`timescale 1ns/1ps
module mas_serial_port_test;
    logic clk, reset, sclk, csN, sdi, sdoData, sdoOeN, txValid, txReady;
    logic rxValid, frameActive, frameStart, alarmEvent, alarmClear;
    logic alarmPinOut, alarmPinOeN;
    logic [7:0] txWord, rxWord;
    mas_pkg::mas_alarm_cfg_s alarmCfg;
    logic [15:0] rxQ[$];
    logic [31:0] seed = 32'h2a7f;
    int n_mismatch = 0, n_tests = 0, cyc = 0;
    int nStarts = 0, nFrames = 0;
    mas_serial_port dut (.clk(clk), .reset(reset), .sclk(sclk), .csN(csN), .sdi(sdi),
        .sdoData(sdoData), .sdoOeN(sdoOeN), .txWord(txWord), .txValid(txValid),
        .txReady(txReady), .rxWord(rxWord), .rxValid(rxValid), .frameActive(frameActive),
        .frameStart(frameStart), .alarmEvent(alarmEvent), .alarmClear(alarmClear),
        .alarmCfg(alarmCfg), .alarmPinOut(alarmPinOut), .alarmPinOeN(alarmPinOeN));
    mas_host_master host (.sclk(sclk), .csN(csN), .sdi(sdi), .sdoData(sdoData));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    task automatic cmp(input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %0t exp %h got %h", $time, e, g);
        end
    endtask
    task automatic end_sim;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(posedge clk) begin
        #2;
        if (rxValid === 1'b1) begin
            cmp(rxQ.size() > 0 ? rxQ.pop_front() : 16'hffff, {8'h00, rxWord});
        end
        if (frameStart === 1'b1) begin
            nStarts++;
        end
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 12000) begin
            n_mismatch++;
            end_sim;
        end
    end
    task automatic alarm(input logic [1:0] c, input logic ev, input logic cl, input logic on);
        logic [1:0] expPin;
        // open-drain: level 0, enable off whenever the polarity-selected pin level is high
        expPin = c[1] ? {1'b0, c[0] ~^ on} : {c[0] ~^ on, 1'b0};
        @(posedge clk) #1 alarmCfg = c;
        alarmEvent = ev;
        alarmClear = cl;
        @(posedge clk) #1 {alarmEvent, alarmClear} = 2'b00;
        repeat (2) @(posedge clk);
        #1 cmp({14'h0000, expPin}, {14'h0000, alarmPinOut, alarmPinOeN});
    endtask
    task automatic frame(input logic cpol, input int n);
        logic [15:0] miso;
        logic [7:0]  tx;
        int          k;
        seed = xs(seed);
        tx = seed[31:24];
        @(posedge clk) #1 txWord = tx;
        txValid = 1'b1;
        for (k = 0; k < 100 && txReady !== 1'b1; k++) @(posedge clk) #1;
        @(posedge clk) #1 txValid = 1'b0;
        for (k = 8; k <= n; k += 8) rxQ.push_back(seed[n-k +: 8]);
        host.xfer(cpol, n, seed[15:0], miso);
        cmp({tx, tx} >> (16 - n), miso);
        repeat (20) @(posedge clk);
        #1 nFrames++;
        cmp(16'h0000, 16'(rxQ.size()));
        cmp(16'h0001, {14'h0000, frameActive, sdoOeN});
        cmp(16'(nFrames), 16'(nStarts));
    endtask
    initial begin
        {txWord, txValid, alarmEvent, alarmClear, alarmCfg} = '0;
        reset = 1'b1;
        repeat (16) @(posedge clk);
        #1 reset = 1'b0;
        for (int m = 0; m < 4; m++) begin
            alarm(m[1:0], 1'b1, 1'b0, 1'b1);
            alarm(m[1:0], 1'b0, 1'b1, 1'b0);
            alarm(m[1:0], 1'b1, 1'b1, 1'b1);
            alarm(m[1:0], 1'b0, 1'b1, 1'b0);
        end
        for (int m = 0; m < 4; m++) frame(m[0], 16);
        frame(1'b1, 5);
        frame(1'b0, 8);
        host.idle_clocks(6);
        frame(1'b1, 8);
        end_sim;
    end
endmodule // mas_serial_port_test

//--- rtl/mas_alarm_out.sv
// alarm output driver: sticky alarm with push-pull or open-drain, selectable polarity
// assumes event, clear and configuration come from logic on clk
`timescale 1ns/1ps
`include "mas_regs.svh"

module mas_alarm_out (
    input  wire logic                    clk,
    input  wire logic                    reset,
    input  wire logic                    alarmEvent,
    input  wire logic                    alarmClear,
    input  wire mas_pkg::mas_alarm_cfg_s alarmCfg,
    output mas_pkg::mas_pin_s            alarmPin
);

    logic              alarm_ff;
    logic              nxt_alarm;
    mas_pkg::mas_pin_s pin_ff;
    mas_pkg::mas_pin_s nxt_pin;
    logic              assertLevel;

    always_comb begin
        // event wins over a clear in the same cycle
        nxt_alarm = (alarm_ff & ~alarmClear) | alarmEvent;
        assertLevel = alarmCfg.activeHigh ? nxt_alarm : ~nxt_alarm;
        if (alarmCfg.openDrain) begin
            // only pulls low; a high level is a released pin
            nxt_pin.level = 1'b0;
            nxt_pin.oeN   = assertLevel;
        end else begin
            nxt_pin.level = assertLevel;
            nxt_pin.oeN   = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            alarm_ff     <= 1'b0;
            pin_ff.level <= 1'b0;
            pin_ff.oeN   <= 1'b1;
        end else begin
            alarm_ff <= nxt_alarm;
            pin_ff   <= nxt_pin;
        end
    end

    assign alarmPin = pin_ff;

endmodule // mas_alarm_out

//--- rtl/mas_serial_port.sv
// serial slave port of the monitor converter plus its alarm pin
// assumes sclk and csN come from an external master; core logic runs on clk
//
// Summary of operation
// - sample serial input on rising clock edges
// - change serial output on falling clock edges
// - output released whenever select is high
// - select high resets shifter and bit counters, drops partial word
// - clock edges ignored while select is high
// - alarm pin push-pull or open-drain, selectable polarity
// - works with clock idling low or high
// - select falling edge starts a new frame
// - alarm asserts from core events, no transfer
`timescale 1ns/1ps
`include "mas_regs.svh"

module mas_serial_port #(
    parameter int WORD_W = `MAS_WORD_W
) (
    input  wire logic                    clk,
    input  wire logic                    reset,
    input  wire logic                    sclk,
    input  wire logic                    csN,
    input  wire logic                    sdi,
    output logic                         sdoData,
    output logic                         sdoOeN,
    input  wire logic [WORD_W-1:0]       txWord,
    input  wire logic                    txValid,
    output logic                         txReady,
    output logic [WORD_W-1:0]            rxWord,
    output logic                         rxValid,
    output logic                         frameActive,
    output logic                         frameStart,
    input  wire logic                    alarmEvent,
    input  wire logic                    alarmClear,
    input  wire mas_pkg::mas_alarm_cfg_s alarmCfg,
    output logic                         alarmPinOut,
    output logic                         alarmPinOeN
);

    localparam int CNT_W = $clog2(WORD_W);
    localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(WORD_W - 1);

    // ---------------- core domain: reset toward the link ----------------
    logic portRst_ff;

    always_ff @(posedge clk) begin
        portRst_ff <= reset;
    end

    // ---------------- link domain, rising edge ----------------
    logic [WORD_W-1:0] rxShift_ff;
    logic [WORD_W-1:0] nxt_rxShift;
    logic [CNT_W-1:0]  rxCnt_ff;
    logic [CNT_W-1:0]  nxt_rxCnt;
    logic              seenRise_ff;
    logic [WORD_W-1:0] rxHold_ff;
    logic [WORD_W-1:0] nxt_rxHold;
    logic              rxTgl_ff;
    logic              nxt_rxTgl;
    logic              wordDone;

    always_comb begin
        nxt_rxShift = {rxShift_ff[WORD_W-2:0], sdi};
        wordDone    = (rxCnt_ff == LAST_BIT);
        nxt_rxCnt   = wordDone ? '0 : rxCnt_ff + CNT_W'(1);
        nxt_rxHold  = wordDone ? nxt_rxShift : rxHold_ff;
        nxt_rxTgl   = rxTgl_ff ^ wordDone;
    end

    // select high holds the shifter in reset and discards a partial word
    always_ff @(posedge sclk or posedge csN) begin
        if (csN) begin
            rxShift_ff  <= `MAS_RX_RESET;
            rxCnt_ff    <= '0;
            seenRise_ff <= 1'b0;
        end else begin
            rxShift_ff  <= nxt_rxShift;
            rxCnt_ff    <= nxt_rxCnt;
            seenRise_ff <= 1'b1;
        end
    end

    // completed words survive the frame so the core can still collect them
    always_ff @(posedge sclk or posedge portRst_ff) begin
        if (portRst_ff) begin
            rxHold_ff <= `MAS_RX_RESET;
            rxTgl_ff  <= 1'b0;
        end else begin
            rxHold_ff <= nxt_rxHold;
            rxTgl_ff  <= nxt_rxTgl;
        end
    end

    // ---------------- link domain, falling edge ----------------
    logic [CNT_W-1:0] txCnt_ff;
    logic [CNT_W-1:0] nxt_txCnt;
    logic             shiftOut;

    always_comb begin
        // falling edges before the first rising edge only occur with idle-high clock
        shiftOut  = seenRise_ff;
        nxt_txCnt = shiftOut ? txCnt_ff + CNT_W'(1) : txCnt_ff;
        if (shiftOut && txCnt_ff == LAST_BIT) begin
            nxt_txCnt = '0;
        end
    end

    always_ff @(negedge sclk or posedge csN) begin
        if (csN) begin
            txCnt_ff <= '0;
        end else begin
            txCnt_ff <= nxt_txCnt;
        end
    end

    // ---------------- core domain: synchronisers ----------------
    logic [`MAS_SYNC_STAGES-1:0] csSync_ff;
    logic [`MAS_SYNC_STAGES-1:0] rxSync_ff;

    always_ff @(posedge clk) begin
        if (reset) begin
            csSync_ff <= '1;
            rxSync_ff <= '0;
        end else begin
            csSync_ff <= {csSync_ff[`MAS_SYNC_STAGES-2:0], csN};
            rxSync_ff <= {rxSync_ff[`MAS_SYNC_STAGES-2:0], rxTgl_ff};
        end
    end

    logic csLow;
    logic rxTglSync;

    assign csLow     = ~csSync_ff[`MAS_SYNC_STAGES-1];
    assign rxTglSync = rxSync_ff[`MAS_SYNC_STAGES-1];

    // ---------------- core domain: frame tracking ----------------
    mas_pkg::mas_frame_e frame_ff;
    mas_pkg::mas_frame_e nxt_frame;
    logic                frameStart_ff;
    logic                nxt_frameStart;

    always_comb begin
        nxt_frame      = frame_ff;
        nxt_frameStart = 1'b0;
        unique case (frame_ff)
            mas_pkg::MAS_IDLE: begin
                if (csLow) begin
                    nxt_frame      = mas_pkg::MAS_FRAME;
                    nxt_frameStart = 1'b1;
                end
            end
            mas_pkg::MAS_FRAME: begin
                if (!csLow) begin
                    nxt_frame = mas_pkg::MAS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            frame_ff      <= mas_pkg::MAS_IDLE;
            frameStart_ff <= 1'b0;
        end else begin
            frame_ff      <= nxt_frame;
            frameStart_ff <= nxt_frameStart;
        end
    end

    // ---------------- core domain: received words ----------------
    logic              rxSeen_ff;
    logic              rxValid_ff;
    logic              nxt_rxValid;
    logic [WORD_W-1:0] rxWord_ff;
    logic [WORD_W-1:0] nxt_rxWord;

    always_comb begin
        // hold register is stable for a whole word time after the toggle
        nxt_rxValid = rxTglSync ^ rxSeen_ff;
        nxt_rxWord  = nxt_rxValid ? rxHold_ff : rxWord_ff;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rxSeen_ff  <= rxTglSync;
            rxValid_ff <= 1'b0;
            rxWord_ff  <= `MAS_RX_RESET;
        end else begin
            rxSeen_ff  <= rxTglSync;
            rxValid_ff <= nxt_rxValid;
            rxWord_ff  <= nxt_rxWord;
        end
    end

    // ---------------- core domain: word to transmit ----------------
    logic [WORD_W-1:0] txWord_ff;
    logic [WORD_W-1:0] nxt_txWord;
    logic              txReady_ff;
    logic              nxt_txReady;

    always_comb begin
        // the word only changes between frames, so the link reads it as static
        nxt_txReady = (nxt_frame == mas_pkg::MAS_IDLE) && !csLow;
        nxt_txWord  = (txValid && txReady_ff) ? txWord : txWord_ff;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            txWord_ff  <= `MAS_TX_RESET;
            txReady_ff <= 1'b0;
        end else begin
            txWord_ff  <= nxt_txWord;
            txReady_ff <= nxt_txReady;
        end
    end

    // ---------------- pin drive ----------------
    // output bit picked straight from the idle-stable word by the falling-edge count
    assign sdoData = txWord_ff[LAST_BIT - txCnt_ff];
    assign sdoOeN  = csN;

    assign txReady     = txReady_ff;
    assign rxWord      = rxWord_ff;
    assign rxValid     = rxValid_ff;
    assign frameActive = (frame_ff == mas_pkg::MAS_FRAME);
    assign frameStart  = frameStart_ff;

    // ---------------- alarm pin ----------------
    mas_pkg::mas_pin_s alarmPin;

    mas_alarm_out u_alarm (
        .clk        (clk),
        .reset      (reset),
        .alarmEvent (alarmEvent),
        .alarmClear (alarmClear),
        .alarmCfg   (alarmCfg),
        .alarmPin   (alarmPin)
    );

    assign alarmPinOut = alarmPin.level;
    assign alarmPinOeN = alarmPin.oeN;

endmodule // mas_serial_port

//--- shared/mas_pkg.sv
// types shared by the monitor serial port and its alarm driver
// assumes mas_regs.svh sits beside it on the include path
`include "mas_regs.svh"

package mas_pkg;

    typedef logic [`MAS_WORD_W-1:0] mas_word_t;

    // alarm pin configuration, held by the core
    typedef struct packed {
        logic openDrain;
        logic activeHigh;
    } mas_alarm_cfg_s;

    // driven state of a pin: level plus active-low output enable
    typedef struct packed {
        logic level;
        logic oeN;
    } mas_pin_s;

    typedef enum logic [0:0] {
        MAS_IDLE,
        MAS_FRAME
    } mas_frame_e;

endpackage

//--- shared/mas_regs.svh
// constants of the monitor serial port: word size, sync depth, transmit and receive reset values
// assumes inclusion by bare name from design files
`ifndef MAS_REGS_SVH
`define MAS_REGS_SVH

`define MAS_WORD_W      8
`define MAS_SYNC_STAGES 2
`define MAS_TX_RESET    8'h00
`define MAS_RX_RESET    8'h00

`endif
